// ===== pkg/isc_pkg.sv
// Purpose: Shared constants and types for the I2C slave control block
// Assumes: Single 200 MHz system clock, synchronous active-low reset
// Notes: No software registers; control bits arrive as plain inputs
package isc_pkg;
  localparam int ADDR_WIDTH = 7;
  localparam int BYTE_BITS = 8;
  localparam logic [2:0] LAST_BIT_IDX = 3'h7;
  localparam logic [2:0] BIT_CNT_RESET = 3'h0;
  localparam logic [7:0] SHIFT_RESET = 8'h00;
  localparam logic [1:0] SYNC_RESET = 2'h3;
  localparam logic [6:0] SLAVE_ADDR_DEFAULT = 7'h2a;

  typedef enum logic [2:0] {
    ISC_IDLE = 3'b000,
    ISC_ADDR = 3'b001,
    ISC_ADDR_ACK = 3'b010,
    ISC_RX = 3'b011,
    ISC_RX_ACK = 3'b100,
    ISC_TX = 3'b101,
    ISC_TX_ACK = 3'b110
  } isc_state_type;
endpackage : isc_pkg

// ===== pkg/isc_line_if.sv
// Purpose: Carries synchronised bus levels and detected events
// Assumes: All signals on clk, one-cycle event pulses
// Notes: Driven by the line conditioner, read by the control core
`timescale 1ns/1ps
interface isc_line_if;
  logic sclLevel;
  logic sdaLevel;
  logic sclRise;
  logic sclFall;
  logic startSeen;
  logic stopSeen;
  modport cond (output sclLevel, sdaLevel, sclRise, sclFall, startSeen, stopSeen);
  modport core (input sclLevel, sdaLevel, sclRise, sclFall, startSeen, stopSeen);
endinterface : isc_line_if

// ===== src/isc_line_cond.sv
// Purpose: Synchronise SCL and SDA pins and detect edges, start and stop
// Assumes: Pins are asynchronous to clk
// Notes: Events are one-cycle pulses, delayed two clocks from the pin
`timescale 1ns/1ps
module isc_line_cond (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clkEn,
  input wire logic sclPin,
  input wire logic sdaPin,
  isc_line_if.cond line
);
  logic [1:0] sclSync;
  logic [1:0] sdaSync;
  logic sclLast;
  logic sdaLast;

  // First stage feeds only the second stage
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      sclSync <= isc_pkg::SYNC_RESET;
      sdaSync <= isc_pkg::SYNC_RESET;
    end else if (clkEn) begin
      sclSync <= {sclSync[0], sclPin};
      sdaSync <= {sdaSync[0], sdaPin};
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      sclLast <= 1'b1;
      sdaLast <= 1'b1;
    end else if (clkEn) begin
      sclLast <= sclSync[1];
      sdaLast <= sdaSync[1];
    end
  end

  assign line.sclLevel = sclSync[1];
  assign line.sdaLevel = sdaSync[1];
  assign line.sclRise = sclSync[1] & ~sclLast;
  assign line.sclFall = ~sclSync[1] & sclLast;
  // SDA moving while SCL stays high marks start or stop
  assign line.startSeen = sclSync[1] & sclLast & sdaLast & ~sdaSync[1];
  assign line.stopSeen = sclSync[1] & sclLast & ~sdaLast & sdaSync[1];
endmodule : isc_line_cond

// ===== src/isc_slave_ctrl.sv
// Purpose: I2C slave byte engine honouring stop-irq, forced nack and early tx control bits
// Assumes: External master drives SCL; SDA is open drain, sdaOut always low
// Notes: Control bits are plain level inputs written elsewhere by software
// Function
// - A stop condition raises the stop interrupt only while its enable is set.
// - With forced not-ack set the slave answers the next byte with a not-ack.
// - With forced not-ack clear the slave decides the acknowledge itself.
// - With early-tx set the tx request fires just after SCL rises on the read bit.
// - With early-tx clear the tx request fires just after SCL falls on the read bit.
`timescale 1ns/1ps
module isc_slave_ctrl #(
  parameter logic [6:0] SLAVE_ADDR = isc_pkg::SLAVE_ADDR_DEFAULT
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clkEn,
  input wire logic sclPin,
  input wire logic sdaPin,
  output logic sdaOut,
  output logic sdaOe,
  input wire logic stop_detect_irq_enable,
  input wire logic force_not_ack_next_byte,
  input wire logic early_tx_request_select,
  input wire logic reservedCtrlBit,
  input wire logic rxBufferFull,
  input wire logic [7:0] txData,
  output logic [7:0] rxData,
  output logic rxValid,
  output logic stopIrq,
  output logic txRequestIrq,
  output logic busActive
);
  isc_line_if line ();
  isc_pkg::isc_state_type state;
  logic [2:0] bitCnt;
  logic [7:0] shift;
  logic byteDone;
  logic rwBit;
  logic addrHit;

  isc_line_cond u_cond (
    .clk(clk),
    .reset_n(reset_n),
    .clkEn(clkEn),
    .sclPin(sclPin),
    .sdaPin(sdaPin),
    .line(line.cond)
  );

  // Hardware view of the acknowledge, before any forced not-ack
  function automatic logic hw_ack(input logic isAddr, input logic hit, input logic full);
    hw_ack = isAddr ? hit : ~full;
  endfunction : hw_ack

  // Level input only: forcing persists as long as software holds it
  function automatic logic final_ack(input logic hwDecision, input logic forceNack);
    final_ack = hwDecision & ~forceNack;
  endfunction : final_ack

  // Reserved bit deliberately unused
  logic unusedReserved;
  assign unusedReserved = reservedCtrlBit;
  assign sdaOut = 1'b0;

  wire lastRise = line.sclRise && (bitCnt == isc_pkg::LAST_BIT_IDX);
  wire addrMatch = (shift[6:0] == SLAVE_ADDR);

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state <= isc_pkg::ISC_IDLE;
      bitCnt <= isc_pkg::BIT_CNT_RESET;
      shift <= isc_pkg::SHIFT_RESET;
      byteDone <= 1'b0;
      rwBit <= 1'b0;
      addrHit <= 1'b0;
      sdaOe <= 1'b0;
    end else if (clkEn) begin
      if (line.stopSeen) begin
        state <= isc_pkg::ISC_IDLE;
        sdaOe <= 1'b0;
      end else if (line.startSeen) begin
        // Repeated start restarts address phase mid-transfer
        state <= isc_pkg::ISC_ADDR;
        bitCnt <= isc_pkg::BIT_CNT_RESET;
        byteDone <= 1'b0;
        sdaOe <= 1'b0;
      end else begin
        unique case (state)
          isc_pkg::ISC_IDLE: begin
            sdaOe <= 1'b0;
          end
          isc_pkg::ISC_ADDR, isc_pkg::ISC_RX: begin
            if (line.sclRise) begin
              shift <= {shift[6:0], line.sdaLevel};
              bitCnt <= bitCnt + 3'h1;
              if (lastRise) begin
                byteDone <= 1'b1;
                if (state == isc_pkg::ISC_ADDR) begin
                  rwBit <= line.sdaLevel;
                  addrHit <= addrMatch;
                end
              end
            end else if (line.sclFall && byteDone) begin
              byteDone <= 1'b0;
              if (state == isc_pkg::ISC_ADDR) begin
                if (addrHit) begin
                  state <= isc_pkg::ISC_ADDR_ACK;
                  sdaOe <= final_ack(hw_ack(1'b1, addrHit, rxBufferFull),
                                     force_not_ack_next_byte);
                end else begin
                  state <= isc_pkg::ISC_IDLE;
                end
              end else begin
                state <= isc_pkg::ISC_RX_ACK;
                sdaOe <= final_ack(hw_ack(1'b0, addrHit, rxBufferFull),
                                   force_not_ack_next_byte);
              end
            end
          end
          isc_pkg::ISC_ADDR_ACK, isc_pkg::ISC_RX_ACK: begin
            if (line.sclFall) begin
              bitCnt <= isc_pkg::BIT_CNT_RESET;
              if (!sdaOe) begin
                // Not-acknowledged: stay off the bus until stop or start
                state <= isc_pkg::ISC_IDLE;
                sdaOe <= 1'b0;
              end else if (state == isc_pkg::ISC_ADDR_ACK && rwBit) begin
                state <= isc_pkg::ISC_TX;
                shift <= txData;
                sdaOe <= ~txData[7];
              end else begin
                state <= isc_pkg::ISC_RX;
                sdaOe <= 1'b0;
              end
            end
          end
          isc_pkg::ISC_TX: begin
            if (line.sclRise) begin
              bitCnt <= bitCnt + 3'h1;
              byteDone <= (bitCnt == isc_pkg::LAST_BIT_IDX);
            end else if (line.sclFall) begin
              if (byteDone) begin
                byteDone <= 1'b0;
                state <= isc_pkg::ISC_TX_ACK;
                sdaOe <= 1'b0;
              end else begin
                shift <= {shift[6:0], 1'b0};
                sdaOe <= ~shift[6];
              end
            end
          end
          isc_pkg::ISC_TX_ACK: begin
            if (line.sclRise) begin
              // Master not-ack ends the read
              rwBit <= ~line.sdaLevel;
            end else if (line.sclFall) begin
              bitCnt <= isc_pkg::BIT_CNT_RESET;
              if (rwBit) begin
                state <= isc_pkg::ISC_TX;
                shift <= txData;
                sdaOe <= ~txData[7];
              end else begin
                state <= isc_pkg::ISC_IDLE;
                sdaOe <= 1'b0;
              end
            end
          end
          default: begin
            state <= isc_pkg::ISC_IDLE;
            sdaOe <= 1'b0;
          end
        endcase
      end
    end
  end

  // Received byte handed out as it is acknowledged; rxValid stays low when it is refused
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rxData <= isc_pkg::SHIFT_RESET;
      rxValid <= 1'b0;
    end else if (clkEn) begin
      rxValid <= 1'b0;
      if (state == isc_pkg::ISC_RX && line.sclFall && byteDone && !line.stopSeen
          && !line.startSeen) begin
        rxData <= shift;
        rxValid <= final_ack(~rxBufferFull, force_not_ack_next_byte);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      stopIrq <= 1'b0;
    end else if (clkEn) begin
      stopIrq <= line.stopSeen & stop_detect_irq_enable;
    end
  end

  // Read request timing: rising edge of the R/W bit, or its falling edge; later bytes on the rise of the master ack
  wire earlyFire = (state == isc_pkg::ISC_ADDR) && lastRise && line.sdaLevel
                   && addrMatch && early_tx_request_select;
  wire lateFire = (state == isc_pkg::ISC_ADDR) && line.sclFall && byteDone
                  && rwBit && addrHit && !early_tx_request_select;
  wire nextFire = (state == isc_pkg::ISC_TX_ACK) && line.sclRise && !line.sdaLevel;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      txRequestIrq <= 1'b0;
    end else if (clkEn) begin
      txRequestIrq <= (earlyFire | lateFire | nextFire) & ~line.stopSeen
                      & ~line.startSeen;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      busActive <= 1'b0;
    end else if (clkEn) begin
      if (line.stopSeen) begin
        busActive <= 1'b0;
      end else if (line.startSeen) begin
        busActive <= 1'b1;
      end
    end
  end

  property p_stop_irq;
    @(posedge clk) disable iff (!reset_n)
      clkEn && line.stopSeen |=> stopIrq == $past(stop_detect_irq_enable);
  endproperty
  a_stop_irq_gate: assert property (p_stop_irq) else $error("stop irq gating wrong");

  a_forced_nack: assert property (@(posedge clk) disable iff (!reset_n)
    clkEn && state == isc_pkg::ISC_RX && line.sclFall && byteDone && force_not_ack_next_byte
    && !line.stopSeen && !line.startSeen |=> state == isc_pkg::ISC_RX_ACK && !sdaOe)
    else $error("forced nack not driven");

  a_hw_ack: assert property (@(posedge clk) disable iff (!reset_n)
    clkEn && state == isc_pkg::ISC_RX && line.sclFall && byteDone && !force_not_ack_next_byte
    && !line.stopSeen && !line.startSeen |=> sdaOe == !$past(rxBufferFull))
    else $error("hardware ack decision wrong");

  a_nack_persist: assert property (@(posedge clk) disable iff (!reset_n)
    clkEn && force_not_ack_next_byte && $past(force_not_ack_next_byte)
    && state == isc_pkg::ISC_ADDR_ACK && $past(state) == isc_pkg::ISC_ADDR |-> !sdaOe)
    else $error("forced nack dropped");

  a_early_tx_req: assert property (@(posedge clk) disable iff (!reset_n)
    clkEn && earlyFire && !line.stopSeen && !line.startSeen ##1 clkEn [*1] |-> txRequestIrq)
    else $error("early tx request missing");

  a_late_tx_req: assert property (@(posedge clk) disable iff (!reset_n)
    clkEn && state == isc_pkg::ISC_ADDR && lastRise && !early_tx_request_select
    |=> !txRequestIrq)
    else $error("tx request fired on rising edge");

  a_late_tx_fall: assert property (@(posedge clk) disable iff (!reset_n)
    clkEn && lateFire && !line.stopSeen && !line.startSeen |=> txRequestIrq)
    else $error("late tx request missing");

  c_read_addr: cover property (@(posedge clk) disable iff (!reset_n)
    state == isc_pkg::ISC_ADDR_ACK ##[1:1000] state == isc_pkg::ISC_TX);
  c_forced_nack: cover property (@(posedge clk) disable iff (!reset_n)
    state == isc_pkg::ISC_RX_ACK && !sdaOe);
  c_stop_irq: cover property (@(posedge clk) disable iff (!reset_n) stopIrq);
endmodule : isc_slave_ctrl

// ===== test/isc_master_model.sv
// Purpose: Behavioural I2C master driving SCL and pulling SDA low
// Assumes: SDA has a pull-up; 80 ns SCL period
// Notes: SCL rests high between frames; SDA is never driven high
`timescale 1ns/1ps
module isc_master_model (
  input wire logic sdaIn,
  output logic scl = 1'b1,
  output logic sdaLow = 1'b0
);
  // Data changes only while SCL is low, so no false start or stop
  task automatic bitx(input logic b, output logic r);
    sdaLow = ~b;
    #20 scl = 1'b1;
    #20 r = sdaIn;
    #20 scl = 1'b0;
    #20;
  endtask : bitx

  task automatic startCond();
    sdaLow = 1'b1;
    #20 scl = 1'b0;
    #20;
  endtask : startCond

  task automatic stopCond();
    sdaLow = 1'b1;
    #20 scl = 1'b1;
    #20 sdaLow = 1'b0;
    #40;
  endtask : stopCond

  // MSB first, then the slave's acknowledge slot
  task automatic sendByte(input logic [7:0] d, output logic a);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bitx(d[i], r);
    end
    bitx(1'b1, r);
    a = ~r;
  endtask : sendByte

  task automatic getByte(input logic ack, output logic [7:0] d);
    logic r;
    for (int i = 0; i < 8; i++) begin
      bitx(1'b1, r);
      d = {d[6:0], r};
    end
    bitx(~ack, r);
  endtask : getByte
endmodule : isc_master_model

// ===== test/i2c_slave_control_bits_tb.sv
// Purpose: Self-checking bench for the I2C slave control bits
// Assumes: Master model on SCL/SDA, SDA pulled up, 200 MHz clk
// Notes: Random data from a fixed seed; run cut by a cycle ceiling
`timescale 1ns/1ps
module i2c_slave_control_bits_tb;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic stopEn = 1'b0;
  logic forceNack = 1'b0;
  logic earlySel = 1'b0;
  logic bufFull = 1'b0;
  logic [7:0] txByte = 8'h00;
  logic reqHi = 1'b0;
  logic reqLo = 1'b0;
  logic clrCnt = 1'b0;
  int errors = 0;
  int num_checks = 0;
  int cyc = 0;
  int stopCnt = 0;
  int rxCnt = 0;
  int reqCnt = 0;
  // Tests need a few thousand cycles; the ceiling leaves wide margin
  localparam int CYCLE_LIMIT = 20000;
  wire logic scl, sdaLow, sdaOut, sdaOe, rxValid, stopIrq, txReq, busActive;
  wire logic [7:0] rxData;
  wire logic sdaPin = ~(sdaLow | (sdaOe & ~sdaOut));

  isc_master_model u_isc_master_model (.sdaIn(sdaPin), .scl(scl), .sdaLow(sdaLow));

  isc_slave_ctrl u_isc_slave_ctrl (
    .clk(clk), .reset_n(reset_n), .clkEn(1'b1), .sclPin(scl), .sdaPin(sdaPin),
    .sdaOut(sdaOut), .sdaOe(sdaOe), .stop_detect_irq_enable(stopEn),
    .force_not_ack_next_byte(forceNack), .early_tx_request_select(earlySel),
    .reservedCtrlBit(1'b0),
    .rxBufferFull(bufFull), .txData(txByte), .rxData(rxData), .rxValid(rxValid),
    .stopIrq(stopIrq), .txRequestIrq(txReq), .busActive(busActive)
  );

  initial begin
    forever #2.5 clk = ~clk;
  end

  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : finish_test

  task automatic check(input string n, input logic [7:0] s, input logic [7:0] e);
    num_checks++;
    if (s !== e) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask : check

  // Address refused only when forced; data also refused when forced or buffer full
  function automatic logic exp_ack(input logic isData, fAddr, fData, full);
    return ~fAddr & (~isData | (~fData & ~full));
  endfunction : exp_ack

  // Counters are cleared through the monitor so only one process writes them
  task automatic setCtl(input logic en, f, e, full);
    @(posedge clk);
    stopEn <= en;
    forceNack <= f;
    earlySel <= e;
    bufFull <= full;
    txByte <= 8'($urandom);
    clrCnt <= 1'b1;
    @(posedge clk);
    clrCnt <= 1'b0;
    #1;
  endtask : setCtl

  // Forced not-ack may change between the address and the data byte
  task automatic wr(input logic en, fAddr, fData, full);
    logic a;
    logic expA;
    logic expD;
    logic [7:0] d;
    d = 8'($urandom);
    expA = exp_ack(1'b0, fAddr, fData, full);
    expD = exp_ack(1'b1, fAddr, fData, full);
    setCtl(en, fAddr, 1'b0, full);
    u_isc_master_model.startCond();
    u_isc_master_model.sendByte({isc_pkg::SLAVE_ADDR_DEFAULT, 1'b0}, a);
    check("addr ack", {7'h00, a}, {7'h00, expA});
    check("bus busy", {7'h00, busActive}, 8'h01);
    @(posedge clk);
    forceNack <= fData;
    #1;
    u_isc_master_model.sendByte(d, a);
    check("data ack", {7'h00, a}, {7'h00, expD});
    if (expD === 1'b1) check("rx data", rxData, d);
    u_isc_master_model.stopCond();
    repeat (8) @(posedge clk);
    check("stop irq", 8'(stopCnt), {7'h00, en});
    check("rx count", 8'(rxCnt), {7'h00, expD});
    check("bus idle", {7'h00, busActive}, 8'h00);
    check("sda out", {7'h00, sdaOut}, 8'h00);
    $display("test write done");
  endtask : wr

  // Two bytes: the master acks the first and refuses the second
  task automatic rd(input logic e);
    logic a;
    logic [7:0] d;
    setCtl(1'b0, 1'b0, e, 1'b0);
    u_isc_master_model.startCond();
    u_isc_master_model.sendByte({isc_pkg::SLAVE_ADDR_DEFAULT, 1'b1}, a);
    check("read ack", {7'h00, a}, 8'h01);
    u_isc_master_model.getByte(1'b1, d);
    check("read data", d, txByte);
    u_isc_master_model.getByte(1'b0, d);
    check("read data 2", d, txByte);
    u_isc_master_model.stopCond();
    repeat (8) @(posedge clk);
    check("req scl high", {7'h00, reqHi}, {7'h00, e});
    check("req scl low", {7'h00, reqLo}, {7'h00, ~e});
    check("req count", 8'(reqCnt), 8'h02);
    check("no stop irq", 8'(stopCnt), 8'h00);
    $display("test read done");
  endtask : rd

  // Level of SCL at the first pulse tells which edge launched the request
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (clrCnt) begin
      stopCnt <= 0;
      rxCnt <= 0;
      reqCnt <= 0;
      reqHi <= 1'b0;
      reqLo <= 1'b0;
    end else begin
      if (stopIrq === 1'b1) stopCnt <= stopCnt + 1;
      if (rxValid === 1'b1) rxCnt <= rxCnt + 1;
      if (txReq === 1'b1) reqCnt <= reqCnt + 1;
      if (txReq === 1'b1 && reqCnt == 0) begin
        reqHi <= (scl === 1'b1);
        reqLo <= (scl === 1'b0);
      end
    end
  end

  initial begin
    logic f;
    void'($urandom(32'h9a43));
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    repeat (10) @(posedge clk);
    fork
      begin
        wr(1'b1, 1'b0, 1'b0, 1'b0);
        wr(1'b0, 1'b0, 1'b0, 1'b1);
        wr(1'b1, 1'b1, 1'b1, 1'b0);
        wr(1'b0, 1'b0, 1'b1, 1'b0);
        wr(1'b0, 1'b1, 1'b1, 1'b0);
        repeat (3) begin
          f = 1'($urandom);
          wr(1'($urandom), 1'b0, f, 1'($urandom));
        end
        rd(1'b1);
        rd(1'b0);
      end
      begin
        wait (cyc == CYCLE_LIMIT);
        errors++;
      end
    join_any
    finish_test();
  end
endmodule : i2c_slave_control_bits_tb
